// ---- common/pd_mode_pkg.sv ----
// Constants and types shared by the powered-device mode and sleep controller
package pd_mode_pkg;
    localparam int unsigned CLK_HZ = 20000000;
    localparam int unsigned SLEEP_QUAL_S = 6;
    localparam int unsigned SLEEP_QUAL_CYC = SLEEP_QUAL_S * CLK_HZ;
    localparam int unsigned IND_HZ = 250;
    localparam int unsigned IND_PERIOD_CYC = CLK_HZ / IND_HZ;
    localparam int unsigned IND_DUTY_PCT = 25;
    localparam int unsigned IND_HIGH_CYC = IND_PERIOD_CYC * IND_DUTY_PCT / 100;
    localparam int unsigned LIMIT_PULSE_MAX = 15;

    // Register map
    localparam logic [7:0] CTRL_ADDR = 8'h00;
    localparam logic [7:0] STAT_ADDR = 8'h04;
    localparam logic [7:0] LIMIT_ADDR = 8'h08;
    localparam int unsigned CTRL_TIMED_BIT = 0;
    localparam int unsigned CTRL_LIMIT_REQ_BIT = 1;
    localparam logic [31:0] CTRL_RESET = 32'h00000000;

    // Requested power per class in units of 10 mW
    localparam logic [15:0] CLASS_POWER [0:8] = '{16'h050F, 16'h0180, 16'h0289, 16'h050F,
        16'h09F6, 16'h0EF1, 16'h13EC, 16'h17D4, 16'h1BBC};
    localparam logic [3:0] CLASS_OPEN = 4'hF;

    typedef enum logic [1:0] {
        VIN_OFF,
        VIN_DETECT,
        VIN_CLASS,
        VIN_POWER
    } vin_mode_t;

    typedef enum logic [1:0] {
        ST_NORMAL,
        ST_QUAL,
        ST_SLEEP,
        ST_DEEP
    } sleep_state_t;
endpackage

// ---- verilog/pd_mode_sleep_control.sv ----
// Mode selection, sleep control and limit configuration with an AXI4-Lite register slave
// Contract
// - Edge variant sleeps on sleep request falling
// - Timed variant sleeps after 6s held low
// - Wake falling edge returns to normal operation
// - Deep select low enters ultra-low sleep instead
// - Valid limit pulse request overrides class limit
// - Float power-limit; tied low or pulses current-limit
// - Floating loop node disables power limiting
// - Four standby duty settings; two disable autoclass
// - Voltage comparators choose detect, class, power mode
// - Low setting events 1-2, high 3-5
// - Class current off in power mode
// - Requested class maps to requested power
// - Converter hold sink on during sleep
// - Event indicator off during sleep
// - Sleep indicator pulses 250Hz 25% duty
module pd_mode_sleep_control #(
    parameter int unsigned SLEEP_QUAL_CYC = pd_mode_pkg::SLEEP_QUAL_CYC,
    parameter int unsigned IND_PERIOD_CYC = pd_mode_pkg::IND_PERIOD_CYC
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic sleep_request_n,
    input wire logic wake_request_n,
    input wire logic deep_sleep_select_n,
    input wire logic vin_above_detect_min,
    input wire logic vin_above_detect_max,
    input wire logic vin_above_class_min,
    input wire logic vin_above_class_max,
    input wire logic vin_above_turn_on_threshold,
    input wire logic [2:0] class_event_count,
    input wire logic [3:0] class_set_low_events,
    input wire logic [3:0] class_set_high_events,
    input wire logic limit_request_floating,
    input wire logic limit_request_tied_low,
    input wire logic limit_request_pulse_in,
    input wire logic loop_comp_node_floating,
    input wire logic [1:0] standby_duty_select,
    output logic [1:0] vin_mode,
    output logic class_current_enable,
    output logic [3:0] class_setting_active,
    output logic [3:0] requested_class,
    output logic [15:0] requested_power,
    output logic current_limit_mode,
    output logic power_limit_enable,
    output logic [1:0] standby_duty_code,
    output logic autoclass_enable,
    output logic standby_maintain_current,
    output logic deep_sleep_active,
    output logic sleep_active,
    output logic converter_hold_sink,
    output logic event_indicator_enable,
    output logic sleep_indicator_drive
);
    localparam int unsigned IND_HIGH = IND_PERIOD_CYC * pd_mode_pkg::IND_DUTY_PCT / 100;

    // Three-stage synchronisers; a level counts once stages two and three agree
    // Reset to each pin's idle level so that no false edge follows reset
    localparam logic [3:0] PIN_IDLE = 4'h7;
    logic [3:0] pin_raw;
    wire logic [3:0] pin_q;
    wire logic [3:0] pin_nxt;
    logic sl_fall, wk_fall, lp_rise;

    assign pin_raw = {limit_request_pulse_in, deep_sleep_select_n, wake_request_n, sleep_request_n};

    for (genvar g = 0; g < 4; g++) begin : g_sync
        logic [2:0] sync_ff, nxt_sync;
        logic q_ff, nxt_q;
        always_comb begin
            nxt_sync = {sync_ff[1:0], pin_raw[g]};
            nxt_q = (sync_ff[1] == sync_ff[2]) ? sync_ff[2] : q_ff;
        end
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                sync_ff <= {3{PIN_IDLE[g]}};
                q_ff <= PIN_IDLE[g];
            end else begin
                sync_ff <= nxt_sync;
                q_ff <= nxt_q;
            end
        end
        assign pin_q[g] = q_ff;
        assign pin_nxt[g] = nxt_q;
    end

    assign sl_fall = pin_q[0] && !pin_nxt[0];
    assign wk_fall = pin_q[1] && !pin_nxt[1];
    assign lp_rise = !pin_q[3] && pin_nxt[3];

    // Register file
    logic [31:0] ctrl_ff, nxt_ctrl;
    logic [15:0] limit_ff, nxt_limit;
    logic limit_valid_ff, nxt_limit_valid;
    logic aw_ff, w_ff, nxt_aw, nxt_w;
    logic [7:0] awaddr_ff, nxt_awaddr;
    logic [31:0] wdata_ff, nxt_wdata;
    logic [3:0] wstrb_ff, nxt_wstrb;
    logic bvalid_ff, nxt_bvalid, rvalid_ff, nxt_rvalid;
    logic [1:0] bresp_ff, nxt_bresp, rresp_ff, nxt_rresp;
    logic [31:0] rdata_ff, nxt_rdata;
    logic [3:0] pulse_cnt_ff, nxt_pulse_cnt;
    logic timed_variant;
    logic [31:0] status_word;

    pd_mode_pkg::sleep_state_t state_ff, nxt_state;
    logic [31:0] qual_cnt_ff, nxt_qual_cnt;
    logic deep_req_ff, nxt_deep_req;

    assign timed_variant = ctrl_ff[pd_mode_pkg::CTRL_TIMED_BIT];
    assign s_axi_awready = !aw_ff && !bvalid_ff;
    assign s_axi_wready = !w_ff && !bvalid_ff;
    assign s_axi_arready = !rvalid_ff;
    assign s_axi_bvalid = bvalid_ff;
    assign s_axi_bresp = bresp_ff;
    assign s_axi_rvalid = rvalid_ff;
    assign s_axi_rresp = rresp_ff;
    assign s_axi_rdata = rdata_ff;

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] s);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (s[i]) begin
                r[i*8 +: 8] = d[i*8 +: 8];
            end
        end
        return r;
    endfunction

    always_comb begin
        nxt_aw = aw_ff;
        nxt_w = w_ff;
        nxt_awaddr = awaddr_ff;
        nxt_wdata = wdata_ff;
        nxt_wstrb = wstrb_ff;
        nxt_bvalid = bvalid_ff;
        nxt_bresp = bresp_ff;
        nxt_ctrl = ctrl_ff;
        nxt_limit = limit_ff;
        nxt_limit_valid = limit_valid_ff;
        nxt_pulse_cnt = pulse_cnt_ff;
        nxt_rvalid = rvalid_ff;
        nxt_rresp = rresp_ff;
        nxt_rdata = rdata_ff;
        if (s_axi_awvalid && s_axi_awready) begin
            nxt_aw = 1'b1;
            nxt_awaddr = s_axi_awaddr[7:0];
        end
        if (s_axi_wvalid && s_axi_wready) begin
            nxt_w = 1'b1;
            nxt_wdata = s_axi_wdata;
            nxt_wstrb = s_axi_wstrb;
        end
        if (aw_ff && w_ff) begin
            nxt_aw = 1'b0;
            nxt_w = 1'b0;
            nxt_bvalid = 1'b1;
            nxt_bresp = 2'h0;
            case (awaddr_ff)
                pd_mode_pkg::CTRL_ADDR: nxt_ctrl = merge(ctrl_ff, wdata_ff, wstrb_ff) & 32'h00000003;
                pd_mode_pkg::LIMIT_ADDR: begin
                    nxt_limit = 16'(merge({16'h0000, limit_ff}, wdata_ff, wstrb_ff));
                    nxt_limit_valid = 1'b1;
                end
                default: nxt_bresp = 2'h2;
            endcase
        end else if (bvalid_ff && s_axi_bready) begin
            nxt_bvalid = 1'b0;
        end
        // Counted limit pulses form a request; pulses after a software write still win
        if (lp_rise && pulse_cnt_ff != 4'(pd_mode_pkg::LIMIT_PULSE_MAX)) begin
            nxt_pulse_cnt = pulse_cnt_ff + 4'h1;
            nxt_limit_valid = 1'b1;
            nxt_limit = {12'h000, pulse_cnt_ff + 4'h1};
        end
        if (s_axi_arvalid && s_axi_arready) begin
            nxt_rvalid = 1'b1;
            nxt_rresp = 2'h0;
            case (s_axi_araddr[7:0])
                pd_mode_pkg::CTRL_ADDR: nxt_rdata = ctrl_ff;
                pd_mode_pkg::STAT_ADDR: nxt_rdata = status_word;
                pd_mode_pkg::LIMIT_ADDR: nxt_rdata = {15'h0000, limit_valid_ff, limit_ff};
                default: begin
                    nxt_rdata = 32'h00000000;
                    nxt_rresp = 2'h2;
                end
            endcase
        end else if (rvalid_ff && s_axi_rready) begin
            nxt_rvalid = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_ff <= 1'b0;
            w_ff <= 1'b0;
            awaddr_ff <= 8'h00;
            wdata_ff <= 32'h00000000;
            wstrb_ff <= 4'h0;
            bvalid_ff <= 1'b0;
            bresp_ff <= 2'h0;
            ctrl_ff <= pd_mode_pkg::CTRL_RESET;
            limit_ff <= 16'h0000;
            limit_valid_ff <= 1'b0;
            pulse_cnt_ff <= 4'h0;
            rvalid_ff <= 1'b0;
            rresp_ff <= 2'h0;
            rdata_ff <= 32'h00000000;
        end else begin
            aw_ff <= nxt_aw;
            w_ff <= nxt_w;
            awaddr_ff <= nxt_awaddr;
            wdata_ff <= nxt_wdata;
            wstrb_ff <= nxt_wstrb;
            bvalid_ff <= nxt_bvalid;
            bresp_ff <= nxt_bresp;
            ctrl_ff <= nxt_ctrl;
            limit_ff <= nxt_limit;
            limit_valid_ff <= nxt_limit_valid;
            pulse_cnt_ff <= nxt_pulse_cnt;
            rvalid_ff <= nxt_rvalid;
            rresp_ff <= nxt_rresp;
            rdata_ff <= nxt_rdata;
        end
    end

    // Sleep state machine; wake has priority over a same-cycle sleep edge
    always_comb begin
        nxt_state = state_ff;
        nxt_qual_cnt = qual_cnt_ff;
        nxt_deep_req = deep_req_ff;
        case (state_ff)
            pd_mode_pkg::ST_NORMAL: begin
                nxt_qual_cnt = 32'h00000000;
                if (sl_fall && !wk_fall) begin
                    nxt_deep_req = !pin_q[2];
                    if (timed_variant) begin
                        nxt_state = pd_mode_pkg::ST_QUAL;
                    end else begin
                        nxt_state = pin_q[2] ? pd_mode_pkg::ST_SLEEP : pd_mode_pkg::ST_DEEP;
                    end
                end
            end
            pd_mode_pkg::ST_QUAL: begin
                nxt_qual_cnt = qual_cnt_ff + 32'h00000001;
                if (pin_q[0] || wk_fall) begin
                    nxt_state = pd_mode_pkg::ST_NORMAL;
                end else if (qual_cnt_ff >= SLEEP_QUAL_CYC - 2) begin
                    nxt_state = pin_q[2] ? pd_mode_pkg::ST_SLEEP : pd_mode_pkg::ST_DEEP;
                end
            end
            pd_mode_pkg::ST_SLEEP, pd_mode_pkg::ST_DEEP: begin
                if (wk_fall) begin
                    nxt_state = pd_mode_pkg::ST_NORMAL;
                end
            end
            default: nxt_state = pd_mode_pkg::ST_NORMAL;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_ff <= pd_mode_pkg::ST_NORMAL;
            qual_cnt_ff <= 32'h00000000;
            deep_req_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            qual_cnt_ff <= nxt_qual_cnt;
            deep_req_ff <= nxt_deep_req;
        end
    end

    // Sleep indicator period counter
    logic [31:0] ind_cnt_ff, nxt_ind_cnt;
    logic asleep;
    assign asleep = (state_ff == pd_mode_pkg::ST_SLEEP) || (state_ff == pd_mode_pkg::ST_DEEP);
    always_comb begin
        nxt_ind_cnt = 32'h00000000;
        if (asleep) begin
            nxt_ind_cnt = (ind_cnt_ff >= IND_PERIOD_CYC - 1) ? 32'h00000000 : ind_cnt_ff + 32'h00000001;
        end
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ind_cnt_ff <= 32'h00000000;
        end else begin
            ind_cnt_ff <= nxt_ind_cnt;
        end
    end

    // Mode, class and limit decode
    pd_mode_pkg::vin_mode_t mode_c;
    logic [3:0] cls_c;
    always_comb begin
        if (vin_above_turn_on_threshold) begin
            mode_c = pd_mode_pkg::VIN_POWER;
        end else if (vin_above_class_min && !vin_above_class_max) begin
            mode_c = pd_mode_pkg::VIN_CLASS;
        end else if (vin_above_detect_min && !vin_above_detect_max) begin
            mode_c = pd_mode_pkg::VIN_DETECT;
        end else begin
            mode_c = pd_mode_pkg::VIN_OFF;
        end
        // Low setting is the class when high is open, else high selects classes 4 to 8
        if (class_set_high_events == pd_mode_pkg::CLASS_OPEN) begin
            cls_c = (class_set_low_events > 4'h3) ? 4'h3 : class_set_low_events;
        end else begin
            cls_c = (class_set_high_events > 4'h4) ? 4'h8 : 4'h4 + class_set_high_events;
        end
    end

    assign vin_mode = mode_c;
    assign class_current_enable = (mode_c == pd_mode_pkg::VIN_CLASS);
    assign class_setting_active = (class_event_count >= 3'h3) ? class_set_high_events : class_set_low_events;
    assign requested_class = cls_c;
    assign requested_power = limit_valid_ff ? limit_ff : pd_mode_pkg::CLASS_POWER[cls_c];
    assign current_limit_mode = !limit_request_floating &&
        (limit_request_tied_low || limit_valid_ff || ctrl_ff[pd_mode_pkg::CTRL_LIMIT_REQ_BIT]);
    assign power_limit_enable = !loop_comp_node_floating;
    assign standby_duty_code = standby_duty_select;
    assign autoclass_enable = standby_duty_select[1];
    assign standby_maintain_current = (mode_c == pd_mode_pkg::VIN_POWER);
    assign deep_sleep_active = (state_ff == pd_mode_pkg::ST_DEEP);
    assign sleep_active = asleep;
    assign converter_hold_sink = asleep;
    assign event_indicator_enable = !asleep && (mode_c == pd_mode_pkg::VIN_POWER);
    assign sleep_indicator_drive = asleep && (ind_cnt_ff < IND_HIGH);
    assign status_word = {22'h000000, deep_req_ff, current_limit_mode, 2'(mode_c), 2'(state_ff), cls_c};

    AST_WAKE_EXIT: assert property (@(posedge aclk) disable iff (!aresetn)
        asleep && wk_fall |=> !asleep) else $error("wake did not exit sleep");
    AST_EDGE_SLEEP: assert property (@(posedge aclk) disable iff (!aresetn)
        state_ff == pd_mode_pkg::ST_NORMAL && !timed_variant && sl_fall && !wk_fall |=> asleep)
        else $error("edge sleep missed");
    AST_TIMED_NO_EARLY: assert property (@(posedge aclk) disable iff (!aresetn)
        state_ff == pd_mode_pkg::ST_NORMAL && timed_variant && sl_fall && !wk_fall |=> !asleep[*2])
        else $error("timed sleep entered early");
    AST_DEEP_SEL: assert property (@(posedge aclk) disable iff (!aresetn)
        $rose(asleep) |-> deep_sleep_active == !$past(pin_q[2])) else $error("deep select wrong");
    AST_HOLD_SINK: assert property (@(posedge aclk) disable iff (!aresetn)
        converter_hold_sink == asleep) else $error("hold sink mismatch");
    AST_EVENT_OFF: assert property (@(posedge aclk) disable iff (!aresetn)
        asleep |-> !event_indicator_enable) else $error("event indicator on in sleep");
    AST_IND_DUTY: assert property (@(posedge aclk) disable iff (!aresetn)
        asleep && ind_cnt_ff == 32'h00000000 |-> sleep_indicator_drive)
        else $error("indicator pulse missing");
    AST_CLASS_OFF: assert property (@(posedge aclk) disable iff (!aresetn)
        vin_above_turn_on_threshold |-> !class_current_enable) else $error("class current in power mode");
    AST_QUAL_RESTART: assert property (@(posedge aclk) disable iff (!aresetn)
        state_ff == pd_mode_pkg::ST_QUAL && pin_q[0] |=> state_ff == pd_mode_pkg::ST_NORMAL)
        else $error("timer not restarted");
endmodule

// ---- test/pse_mcu_model.sv ----
// Far-side model: line voltage seen through the input comparators
module pse_mcu_model #(
    parameter int unsigned DET_MIN_DV = 14,
    parameter int unsigned DET_MAX_DV = 101,
    parameter int unsigned CLS_MIN_DV = 125,
    parameter int unsigned CLS_MAX_DV = 205,
    parameter int unsigned TURN_ON_DV = 354
) (
    input wire logic [9:0] vin_dv,
    output logic above_detect_min,
    output logic above_detect_max,
    output logic above_class_min,
    output logic above_class_max,
    output logic above_turn_on
);
    timeunit 1ns;
    timeprecision 1ns;
    // Voltage in tenths of a volt; ideal comparators, no hysteresis modelled
    assign above_detect_min = (vin_dv >= 10'(DET_MIN_DV));
    assign above_detect_max = (vin_dv > 10'(DET_MAX_DV));
    assign above_class_min = (vin_dv >= 10'(CLS_MIN_DV));
    assign above_class_max = (vin_dv > 10'(CLS_MAX_DV));
    assign above_turn_on = (vin_dv > 10'(TURN_ON_DV));
endmodule

// ---- test/tb_top.sv ----
// Self-checking bench for the mode and sleep controller
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int unsigned QUAL = 100;
    localparam int unsigned PER = 40;
    logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
    logic [31:0] awaddr, wdata, araddr, rdata, rd;
    logic [3:0] wstrb, set_lo, set_hi, class_active, req_class;
    logic [1:0] bresp, rresp, resp, duty_sel, duty_code, vmode;
    logic sleep_request_n, wake_request_n, deep_sleep_select_n, lim_float, lim_low, lim_pulse, loop_float;
    logic det_min, det_max, cls_min, cls_max, turn_on_threshold, cls_en, cur_lim, pwr_lim_en, auto_en, maint;
    logic deep_act, sleep_act, hold_sink, evt_en, ind;
    logic [9:0] vin_dv;
    logic [2:0] ev_count;
    logic [15:0] req_power;
    int num_errors, compares;

    pse_mcu_model u_pse_mcu_model (.vin_dv(vin_dv), .above_detect_min(det_min), .above_detect_max(det_max),
        .above_class_min(cls_min), .above_class_max(cls_max), .above_turn_on(turn_on_threshold));

    pd_mode_sleep_control #(.SLEEP_QUAL_CYC(QUAL), .IND_PERIOD_CYC(PER)) u_pd_mode_sleep_control (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .sleep_request_n(sleep_request_n),
        .wake_request_n(wake_request_n), .deep_sleep_select_n(deep_sleep_select_n),
        .vin_above_detect_min(det_min), .vin_above_detect_max(det_max), .vin_above_class_min(cls_min),
        .vin_above_class_max(cls_max), .vin_above_turn_on_threshold(turn_on_threshold), .class_event_count(ev_count),
        .class_set_low_events(set_lo), .class_set_high_events(set_hi), .limit_request_floating(lim_float),
        .limit_request_tied_low(lim_low), .limit_request_pulse_in(lim_pulse),
        .loop_comp_node_floating(loop_float), .standby_duty_select(duty_sel), .vin_mode(vmode),
        .class_current_enable(cls_en), .class_setting_active(class_active), .requested_class(req_class),
        .requested_power(req_power), .current_limit_mode(cur_lim), .power_limit_enable(pwr_lim_en),
        .standby_duty_code(duty_code), .autoclass_enable(auto_en), .standby_maintain_current(maint),
        .deep_sleep_active(deep_act), .sleep_active(sleep_act), .converter_hold_sink(hold_sink),
        .event_indicator_enable(evt_en), .sleep_indicator_drive(ind));

    initial begin
        aclk = 1'b0;
        forever #25 aclk = ~aclk;
    end

    task automatic results;
        if (num_errors == 0 && compares > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge aclk);
    endtask

    // Write address and data offered together; each dropped once taken
    task automatic axi_write(input logic [31:0] a, input logic [31:0] d);
        logic aw, w, b;
        aw = 1'b1;
        w = 1'b1;
        b = 1'b1;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (b) begin
            @(posedge aclk);
            if (b && bvalid) begin
                b = 1'b0;
                bready <= 1'b0;
                resp = bresp;
            end
            if (aw && awready) begin
                aw = 1'b0;
                awvalid <= 1'b0;
            end
            if (w && wready) begin
                w = 1'b0;
                wvalid <= 1'b0;
            end
        end
    endtask

    task automatic axi_read(input logic [31:0] a);
        logic ar, r;
        ar = 1'b1;
        r = 1'b1;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (r) begin
            @(posedge aclk);
            if (r && rvalid) begin
                r = 1'b0;
                rready <= 1'b0;
                rd = rdata;
                resp = rresp;
            end
            if (ar && arready) begin
                ar = 1'b0;
                arvalid <= 1'b0;
            end
        end
        // Spare edge so back-to-back reads never lower and raise rready in one step
        @(posedge aclk);
    endtask

    // Bounded wait for the sleep flags to reach a level
    task automatic wait_asleep(input logic exp);
        int t;
        t = 0;
        while ((sleep_act | deep_act) !== exp && t < 20) begin
            @(posedge aclk);
            t++;
        end
    endtask

    task automatic t_regs;
        axi_read(32'h00000000);
        chk(rd, 32'h00000000);
        axi_read(32'h00000040);
        chk({30'h0, resp}, 32'h00000002);
        axi_write(32'h00000008, 32'h00010123);
        tick(3);
        chk({16'h0, req_power}, 32'h00000123);
        repeat (3) begin
            lim_pulse <= 1'b1;
            tick(4);
            lim_pulse <= 1'b0;
            tick(4);
        end
        chk({16'h0, req_power}, 32'h00000003);
    endtask

    // Class from the resistor settings, before any limit request overrides the power
    task automatic t_class;
        set_lo <= 4'h0;
        ev_count <= 3'h2;
        tick(2);
        chk({28'h0, class_active}, 32'h00000000);
        chk({28'h0, req_class}, 32'h00000000);
        chk({16'h0, req_power}, 32'h0000050F);
        set_hi <= 4'h1;
        ev_count <= 3'h4;
        tick(2);
        chk({28'h0, class_active}, 32'h00000001);
        chk({28'h0, req_class}, 32'h00000005);
        chk({16'h0, req_power}, 32'h00000EF1);
        set_lo <= 4'h1;
        set_hi <= 4'hF;
        ev_count <= 3'h1;
    endtask

    task automatic t_vin;
        logic [9:0] v [0:3];
        v = '{10'h000, 10'h032, 10'h096, 10'h190};
        for (int i = 0; i < 4; i++) begin
            vin_dv <= v[i];
            tick(5);
            chk({30'h0, vmode}, i);
            chk({31'h0, cls_en}, i == 2);
            axi_read(32'h00000004);
            chk({30'h0, rd[7:6]}, i);
        end
        chk({31'h0, cls_en}, 32'h00000000);
    endtask

    task automatic t_cfg;
        for (int i = 0; i < 4; i++) begin
            duty_sel <= 2'(i);
            tick(4);
            chk({30'h0, duty_code}, i);
            chk({31'h0, auto_en}, i / 2);
        end
        lim_float <= 1'b0;
        lim_low <= 1'b1;
        loop_float <= 1'b1;
        tick(4);
        chk({31'h0, cur_lim}, 32'h00000001);
        chk({31'h0, pwr_lim_en}, 32'h00000000);
        lim_float <= 1'b1;
        lim_low <= 1'b0;
        loop_float <= 1'b0;
        tick(4);
        chk({31'h0, cur_lim}, 32'h00000000);
        chk({31'h0, pwr_lim_en}, 32'h00000001);
    endtask

    task automatic wake;
        sleep_request_n <= 1'b1;
        wake_request_n <= 1'b0;
        tick(6);
        wake_request_n <= 1'b1;
        wait_asleep(1'b0);
        chk({31'h0, sleep_act | deep_act}, 32'h00000000);
        chk({31'h0, evt_en}, 32'h00000001);
    endtask

    // Edge variant sleep, plain or deep, then wake
    task automatic t_sleep(input logic deep);
        int n;
        n = 0;
        deep_sleep_select_n <= ~deep;
        tick(6);
        sleep_request_n <= 1'b0;
        wait_asleep(1'b1);
        chk({31'h0, deep_act}, deep);
        chk({31'h0, hold_sink}, 32'h00000001);
        chk({31'h0, evt_en}, 32'h00000000);
        chk({31'h0, maint}, 32'h00000001);
        repeat (PER) begin
            @(posedge aclk);
            n += int'(ind);
        end
        chk(n, PER / 4);
        wake();
        deep_sleep_select_n <= 1'b1;
        tick(6);
    endtask

    // Timed variant: an early release must restart the qualification count
    task automatic t_timed;
        axi_write(32'h00000000, 32'h00000001);
        sleep_request_n <= 1'b0;
        tick(QUAL / 2);
        sleep_request_n <= 1'b1;
        tick(10);
        chk({31'h0, sleep_act}, 32'h00000000);
        sleep_request_n <= 1'b0;
        tick(QUAL - 5);
        chk({31'h0, sleep_act}, 32'h00000000);
        wait_asleep(1'b1);
        chk({31'h0, sleep_act}, 32'h00000001);
        wake();
        axi_write(32'h00000000, 32'h00000000);
    endtask

    initial begin
        {awvalid, wvalid, bready, arvalid, rready, lim_low, lim_pulse, loop_float} = '0;
        {awaddr, wdata, araddr} = '0;
        wstrb = 4'hF;
        {sleep_request_n, wake_request_n, deep_sleep_select_n, lim_float} = 4'hF;
        vin_dv = 10'h000;
        ev_count = 3'h1;
        set_lo = 4'h1;
        set_hi = 4'hF;
        duty_sel = 2'h0;
        aresetn = 1'b0;
        tick(3);
        aresetn <= 1'b1;
        tick(2);
        t_class();
        t_regs();
        t_vin();
        t_cfg();
        t_sleep(1'b0);
        t_sleep(1'b1);
        t_timed();
        results();
    end

    // Whole run needs well under two thousand cycles
    initial begin
        tick(20000);
        num_errors++;
        results();
    end
endmodule
